//--- rtl/mode_reg_ctrl.sv
// second and third mode registers with the behaviour they steer
//
// Behaviour
// - second register holds until next set
// - bits five to three give write latency
// - total write latency is column plus additive
// - adaptive bit doubles refresh when hot
// - adaptive mode may double below threshold
// - forced bit always gives double refresh
// - bits ten nine select write termination
// - write termination replaces nominal during burst
// - dynamic termination only on writes, not leveling
// - bit two enables pattern, function zero
// - bit two clear means normal array access
// - reads redirect to pattern while enabled
// - reset accepted while pattern enabled
// - pattern repeats on every read
// - reprogramming leaves array contents unchanged
// - pattern alternates zero and one per beat
// - bank code selects second or third register
`timescale 1ns/1ps
`include "mode_reg_defines.svh"
module mode_reg_ctrl (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic link_clk,
	input wire mode_reg_pkg::command_t link_cmd,
	input wire logic [3:0] additive_latency,
	input wire logic [1:0] nominal_termination,
	input wire logic write_leveling,
	input wire logic [7:0] case_temp,
	input wire logic early_hot,
	output logic [1:0] active_termination,
	output logic write_data_latch,
	output logic read_from_array,
	output logic array_write_en,
	output logic pattern_valid,
	output logic pattern_data,
	output mode_reg_pkg::status_t status,
	output logic [3:0] column_write_latency,
	output logic [4:0] total_write_latency,
	output logic bad_setting
);
	import mode_reg_pkg::*;

	// link side reset: asynchronous assert, released through two link flops
	logic link_rst_meta;
	logic link_rst_n;
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			link_rst_meta <= 1'b0;
			link_rst_n <= 1'b0;
		end else begin
			link_rst_meta <= 1'b1;
			link_rst_n <= link_rst_meta;
		end
	end

	// registered command capture on the link clock
	command_t cmd_q;
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cmd_q <= '{op: cmd_nop, bank: 3'h0, addr: 19'h00000};
		end else begin
			cmd_q <= link_cmd;
		end
	end

	logic set_second;
	logic set_third;
	assign set_second = (cmd_q.op == cmd_mode_set) && (cmd_q.bank == `BANK_SEL_SECOND);
	assign set_third = (cmd_q.op == cmd_mode_set) && (cmd_q.bank == `BANK_SEL_THIRD);

	// registers hold until set again; reserved bits stored as zero
	logic [18:0] second_mode_register;
	logic [18:0] third_mode_register;
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			second_mode_register <= `SECOND_RESET;
		end else if (set_second) begin
			second_mode_register <= cmd_q.addr & ~`SECOND_RESERVED_MASK;
		end
	end

	// link reset clears the pattern enable even in pattern mode
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			third_mode_register <= `THIRD_RESET;
		end else if (set_third) begin
			third_mode_register <= cmd_q.addr & ~`THIRD_RESERVED_MASK;
		end
	end

	// pattern only when enabled with the predefined function
	logic cal_on;
	assign cal_on = third_mode_register[`CAL_EN_BIT] &&
		(third_mode_register[`CAL_FUNC_MSB:`CAL_FUNC_LSB] == `CAL_FUNC_PREDEF);

	// reads steer to the pattern, each read restarting a burst
	logic is_read;
	logic pat_start;
	assign is_read = (cmd_q.op == cmd_read) || (cmd_q.op == cmd_read_ap);
	assign pat_start = is_read && third_mode_register[`CAL_EN_BIT] && cal_on;

	// reads reach the array only with the pattern source off
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			read_from_array <= 1'b0;
		end else begin
			read_from_array <= is_read && !third_mode_register[`CAL_EN_BIT];
		end
	end

	// writes reach the array only in normal mode; mode sets never do
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			array_write_en <= 1'b0;
		end else begin
			array_write_en <= (cmd_q.op == cmd_write) && !third_mode_register[`CAL_EN_BIT];
		end
	end

	// burst source for redirected reads
	calib_pattern_gen u_pattern (
		.link_clk(link_clk),
		.link_rst_n(link_rst_n),
		.start(pat_start),
		.beat_valid(pattern_valid),
		.beat_data(pattern_data)
	);

	// latency arithmetic: field code plus base, then add additive
	logic [3:0] cwl_link;
	logic [4:0] wl_link;
	assign cwl_link = 4'({1'b0, second_mode_register[`CWL_MSB:`CWL_LSB]}) + `CWL_BASE;
	assign wl_link = {1'b0, cwl_link} + {1'b0, additive_latency};

	// column latency shown from a flop
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			column_write_latency <= 4'h0;
		end else begin
			column_write_latency <= cwl_link;
		end
	end

	// total latency follows additive changes one cycle later
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			total_write_latency <= 5'h00;
		end else begin
			total_write_latency <= wl_link;
		end
	end

	// latch write data total latency cycles after the write is taken
	logic [4:0] wr_cnt;
	logic [4:0] wr_burst;
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			wr_cnt <= 5'h00;
			write_data_latch <= 1'b0;
		end else if (cmd_q.op == cmd_write && !third_mode_register[`CAL_EN_BIT]) begin
			wr_cnt <= wl_link;
			write_data_latch <= (wl_link == 5'h00);
		end else if (wr_cnt != 5'h00) begin
			wr_cnt <= wr_cnt - 5'h01;
			write_data_latch <= (wr_cnt == 5'h01);
		end else begin
			write_data_latch <= 1'b0;
		end
	end

	// burst window opens at the latch and runs eight more beats after it
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			wr_burst <= 5'h00;
		end else if (write_data_latch) begin
			wr_burst <= 5'({1'b0, `BURST_BEATS});
		end else if (wr_burst != 5'h00) begin
			wr_burst <= wr_burst - 5'h01;
		end
	end

	// write termination replaces nominal, never while leveling
	logic [1:0] wterm;
	logic dyn_on;
	logic [1:0] next_term;
	assign wterm = second_mode_register[`WTERM_MSB:`WTERM_LSB];
	assign dyn_on = (wterm != 2'h0) && !write_leveling;
	always_comb begin
		next_term = nominal_termination;
		if (dyn_on && (wr_burst != 5'h00 || write_data_latch)) begin
			next_term = wterm;
		end
	end

	// termination in force, registered so the output comes from a flop
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			active_termination <= 2'h0;
		end else begin
			active_termination <= next_term;
		end
	end

	// settings the core clock needs, snapshot from flops so no
	// combinational term ever reaches the other domain
	logic [4:0] settings_link;
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			settings_link <= 5'h00;
		end else begin
			settings_link[4] <= second_mode_register[`SRT_BIT];
			settings_link[3] <= second_mode_register[`ASR_BIT];
			settings_link[2] <= cal_on;
			settings_link[1:0] <= wterm;
		end
	end

	// two core flops per bit bring the snapshot across
	logic [4:0] settings_meta;
	logic [4:0] settings_sync;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			settings_meta <= 5'h00;
			settings_sync <= 5'h00;
		end else begin
			settings_meta <= settings_link;
			settings_sync <= settings_meta;
		end
	end

	// bits of one update may land a core cycle apart; a word is used only once seen
	// twice running, one cycle of delay traded for never acting on a torn word
	logic [4:0] settings_prev;
	logic [4:0] settings_held;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			settings_prev <= 5'h00;
			settings_held <= 5'h00;
		end else begin
			settings_prev <= settings_sync;
			if (settings_sync == settings_prev) begin
				settings_held <= settings_sync;
			end
		end
	end

	// named views of the settled word
	logic srt_held;
	logic asr_held;
	logic cal_held;
	logic [1:0] wt_held;
	assign srt_held = settings_held[4];
	assign asr_held = settings_held[3];
	assign cal_held = settings_held[2];
	assign wt_held = settings_held[1:0];

	// temperature pins arrive from outside; two core flops each
	logic [7:0] temp_meta;
	logic [7:0] temp_sync;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			temp_meta <= 8'h00;
			temp_sync <= 8'h00;
		end else begin
			temp_meta <= case_temp;
			temp_sync <= temp_meta;
		end
	end

	// a reading that changes in several bits may arrive torn; keep the last
	// reading seen twice running so the threshold never sees a false value
	logic [7:0] temp_prev;
	logic [7:0] temp_held;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			temp_prev <= 8'h00;
			temp_held <= 8'h00;
		end else begin
			temp_prev <= temp_sync;
			if (temp_sync == temp_prev) begin
				temp_held <= temp_sync;
			end
		end
	end

	// early request pin passes two core flops
	logic hot_meta;
	logic hot_sync;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hot_meta <= 1'b0;
			hot_sync <= 1'b0;
		end else begin
			hot_meta <= early_hot;
			hot_sync <= hot_meta;
		end
	end

	// rate policy runs on the core clock from settled inputs
	logic double_rate;
	refresh_rate_sel u_rate (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.temp_adaptive_refresh(asr_held),
		.forced_double_refresh(srt_held),
		.case_temp(temp_held),
		.early_hot(hot_sync),
		.double_rate(double_rate)
	);

	// flag an illegal pair of refresh bits rather than trust the controller
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bad_setting <= 1'b0;
		end else begin
			bad_setting <= asr_held && srt_held;
		end
	end

	// status mirrors the settings in force, all from core flops
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			status <= '0;
		end else begin
			status.self_refresh_double <= double_rate;
			status.write_term_on <= wt_held != 2'h0;
			status.write_term_sel <= wt_held;
			status.cal_pattern_on <= cal_held;
		end
	end
endmodule

//--- rtl/mode_reg_defines.svh
// constants for the second and third mode register block
`ifndef MODE_REG_DEFINES_SVH
`define MODE_REG_DEFINES_SVH
`define ADDR_WIDTH 19
`define BANK_SEL_SECOND 3'h2
`define BANK_SEL_THIRD 3'h3
`define SECOND_RESERVED_MASK 19'h4f907
`define THIRD_RESERVED_MASK 19'h4fff8
`define CWL_LSB 3
`define CWL_MSB 5
`define ASR_BIT 6
`define SRT_BIT 7
`define WTERM_LSB 9
`define WTERM_MSB 10
`define CAL_EN_BIT 2
`define CAL_FUNC_LSB 0
`define CAL_FUNC_MSB 1
`define CAL_FUNC_PREDEF 2'h0
`define CWL_BASE 4'h5
`define BURST_BEATS 4'h8
`define SECOND_RESET 19'h00000
`define THIRD_RESET 19'h00000
`define TEMP_HOT_LIMIT 8'h55
`endif

//--- rtl/mode_reg_pkg.sv
// types for the second and third mode register block
package mode_reg_pkg;
	typedef enum logic [2:0] {
		cmd_nop = 3'h0,
		cmd_mode_set = 3'h1,
		cmd_read = 3'h2,
		cmd_read_ap = 3'h3,
		cmd_write = 3'h4,
		cmd_other = 3'h5
	} cmd_t;
	typedef struct packed {
		cmd_t op;
		logic [2:0] bank;
		logic [18:0] addr;
	} command_t;
	typedef struct packed {
		logic self_refresh_double;
		logic write_term_on;
		logic [1:0] write_term_sel;
		logic cal_pattern_on;
	} status_t;
endpackage

//--- rtl/refresh_rate_sel.sv
// self refresh rate policy from the adaptive and forced bits
`timescale 1ns/1ps
`include "mode_reg_defines.svh"
module refresh_rate_sel (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic temp_adaptive_refresh,
	input wire logic forced_double_refresh,
	input wire logic [7:0] case_temp,
	input wire logic early_hot,
	output logic double_rate
);
	// rate choice; adaptive mode may go double early, which only helps retention
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			double_rate <= 1'b0;
		end else if (forced_double_refresh) begin
			double_rate <= 1'b1;
		end else if (temp_adaptive_refresh) begin
			double_rate <= (case_temp > `TEMP_HOT_LIMIT) || early_hot;
		end else begin
			double_rate <= 1'b0;
		end
	end
endmodule

//--- rtl/calib_pattern_gen.sv
// calibration pattern burst generator on the link clock
`timescale 1ns/1ps
`include "mode_reg_defines.svh"
module calib_pattern_gen (
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic start,
	output logic beat_valid,
	output logic beat_data
);
	logic [3:0] beat_cnt;
	// alternating beats; a new read restarts the burst so back to back reads repeat
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			beat_cnt <= 4'h0;
			beat_valid <= 1'b0;
			beat_data <= 1'b0;
		end else if (start) begin
			beat_cnt <= 4'h1;
			beat_valid <= 1'b1;
			beat_data <= 1'b0;
		end else if (beat_cnt != 4'h0 && beat_cnt < `BURST_BEATS) begin
			beat_cnt <= beat_cnt + 4'h1;
			beat_valid <= 1'b1;
			beat_data <= ~beat_data;
		end else begin
			beat_cnt <= 4'h0;
			beat_valid <= 1'b0;
			beat_data <= 1'b0;
		end
	end
endmodule

//--- dv/mode_reg_ctrl_asserts.sv
// port checker for the mode register block
`timescale 1ns/1ps
module mode_reg_ctrl_asserts (
	input wire logic arst_n,
	input wire logic link_clk,
	input wire mode_reg_pkg::command_t link_cmd,
	input wire logic [3:0] additive_latency,
	input wire logic [1:0] nominal_termination,
	input wire logic write_leveling,
	input wire logic [1:0] active_termination,
	input wire logic read_from_array,
	input wire logic array_write_en,
	input wire logic pattern_valid,
	input wire logic pattern_data,
	input wire logic [3:0] column_write_latency,
	input wire logic [4:0] total_write_latency
);
	import mode_reg_pkg::*;
	default clocking @(posedge link_clk); endclocking
	default disable iff (!arst_n);
	beat_zero_a: assert property ($rose(pattern_valid) |-> !pattern_data)
		else $error("pattern burst starts high");
	burst_len_a: assert property ($rose(pattern_valid) |-> pattern_valid [*8])
		else $error("pattern burst short");
	// a restarted burst may repeat a zero, so skip beats just after a read
	beat_alt_a: assert property (pattern_valid && $past(pattern_valid) &&
		!($past(link_cmd.op, 2) inside {cmd_read, cmd_read_ap}) |->
		pattern_data != $past(pattern_data))
		else $error("pattern beats do not alternate");
	array_read_a: assert property (read_from_array |->
		$past(link_cmd.op, 2) inside {cmd_read, cmd_read_ap}) else $error("stray array read");
	pattern_cause_a: assert property ($rose(pattern_valid) |->
		$past(link_cmd.op, 2) inside {cmd_read, cmd_read_ap}) else $error("stray pattern burst");
	array_write_a: assert property (array_write_en |-> $past(link_cmd.op, 2) == cmd_write)
		else $error("stray array write");
	cwl_range_a: assert property (column_write_latency != 4'h0 |->
		column_write_latency inside {[4'h5:4'hc]}) else $error("column latency out of range");
	wl_sum_a: assert property (($stable(additive_latency) && $stable(column_write_latency) &&
		column_write_latency != 4'h0) [*3] |->
		total_write_latency == 5'(column_write_latency) + 5'(additive_latency))
		else $error("total latency not a sum");
	level_term_a: assert property ((write_leveling && $stable(nominal_termination)) [*3] |->
		active_termination == nominal_termination) else $error("termination moved in leveling");
	cover property ($rose(pattern_valid));
	cover property (read_from_array);
	cover property (array_write_en);
endmodule

//--- dv/ctrl_model.sv
// controller side model issuing one command per request on the link clock
`timescale 1ns/1ps
`include "mode_reg_defines.svh"
module ctrl_model (
	input wire logic link_clk,
	input wire logic arst_n,
	input wire logic go,
	input wire mode_reg_pkg::command_t req,
	output mode_reg_pkg::command_t link_cmd
);
	import mode_reg_pkg::*;
	command_t clean;
	always_comb begin
		clean = req;
		if (req.op == cmd_mode_set && req.bank == `BANK_SEL_SECOND) begin
			clean.addr = req.addr & ~`SECOND_RESERVED_MASK;
		end
		if (req.op == cmd_mode_set && req.bank == `BANK_SEL_THIRD) begin
			clean.addr = req.addr & ~`THIRD_RESERVED_MASK;
		end
	end
	// bench spaces requests; idle lines toggle so stale values never look valid
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) link_cmd <= '0;
		else if (go) link_cmd <= clean;
		else link_cmd <= '{cmd_nop, ~link_cmd.bank, ~link_cmd.addr};
	end
endmodule

//--- dv/dram_mode_reg2_reg3_control_tb_top.sv
// self-checking bench for the mode register block
`timescale 1ns/1ps
module dram_mode_reg2_reg3_control_tb_top;
	import mode_reg_pkg::*;
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic arst_n = 1'b0;
	logic go = 1'b0;
	command_t req = '0;
	command_t link_cmd;
	logic [3:0] additive_latency = 4'h2;
	logic [1:0] nominal_termination = 2'h1;
	logic write_leveling = 1'b0;
	logic early_hot = 1'b0;
	logic [7:0] case_temp = 8'h14;
	logic [1:0] active_termination;
	logic write_data_latch, read_from_array, array_write_en;
	logic pattern_valid, pattern_data, bad_setting;
	status_t status;
	logic [3:0] column_write_latency;
	logic [4:0] total_write_latency;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #2.5 ref_clk = ~ref_clk;
	always #16 link_clk = ~link_clk;
	mode_reg_ctrl DUT (.ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk),
		.link_cmd(link_cmd), .additive_latency(additive_latency),
		.nominal_termination(nominal_termination), .write_leveling(write_leveling),
		.case_temp(case_temp), .early_hot(early_hot), .active_termination(active_termination),
		.write_data_latch(write_data_latch), .read_from_array(read_from_array),
		.array_write_en(array_write_en), .pattern_valid(pattern_valid),
		.pattern_data(pattern_data), .status(status),
		.column_write_latency(column_write_latency),
		.total_write_latency(total_write_latency), .bad_setting(bad_setting));
	ctrl_model u_ctrl (.link_clk(link_clk), .arst_n(arst_n), .go(go), .req(req),
		.link_cmd(link_cmd));
	task automatic conclude();
		if (bad_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic lw(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask
	task automatic send(input cmd_t op, input logic [2:0] bank, input logic [18:0] addr);
		@(posedge link_clk);
		go <= 1'b1;
		req <= '{op, bank, addr};
		@(posedge link_clk);
		go <= 1'b0;
	endtask
	// long enough to reach the ref_clk status as well
	task automatic mode(input logic [2:0] bank, input logic [18:0] addr);
		send(cmd_mode_set, bank, addr);
		lw(8);
	endtask
	// link edges from the command until any answer, 40 means none
	task automatic answer(input cmd_t op, output int n);
		send(op, 3'h0, 19'h0);
		n = 0;
		do begin
			lw(1);
			n++;
		end while (!(write_data_latch | pattern_valid | read_from_array) && n < 40);
	endtask
	task automatic t_latency();
		int r, w;
		mode(3'h2, 19'h00018);
		chk(column_write_latency, 32'h8);
		chk(total_write_latency, 32'ha);
		answer(cmd_read, r);
		answer(cmd_write, w);
		chk(w - r, 32'ha);
		mode(3'h3, 19'h00000);
		chk(column_write_latency, 32'h8);
	endtask
	task automatic t_refresh();
		@(posedge ref_clk) case_temp <= 8'h55;
		mode(3'h2, 19'h00040); // the adaptive refresh bit is set before running hot
		chk(status.self_refresh_double, 1'b0);
		@(posedge ref_clk) case_temp <= 8'h56;
		lw(3);
		chk(status.self_refresh_double, 1'b1);
		@(posedge ref_clk) case_temp <= 8'h14;
		early_hot <= 1'b1;
		lw(3);
		chk(status.self_refresh_double, 1'b1);
		@(posedge ref_clk) early_hot <= 1'b0;
		mode(3'h2, 19'h00080);
		chk(status.self_refresh_double, 1'b1);
		mode(3'h2, 19'h000c0);
		chk(bad_setting, 1'b1);
		mode(3'h2, 19'h00000);
		chk({bad_setting, status.self_refresh_double}, 2'h0);
	endtask
	task automatic t_term();
		int n;
		mode(3'h2, 19'h00400);
		chk({status.write_term_on, status.write_term_sel}, 3'h6);
		answer(cmd_write, n);
		lw(1);
		chk(active_termination, 2'h2);
		lw(10);
		chk(active_termination, 2'h1);
		@(posedge link_clk) write_leveling <= 1'b1;
		answer(cmd_write, n);
		lw(1);
		chk(active_termination, 2'h1);
		@(posedge link_clk) write_leveling <= 1'b0;
	endtask
	task automatic t_pattern();
		int n;
		mode(3'h3, 19'h00004);
		chk(status.cal_pattern_on, 1'b1);
		for (int k = 0; k < 2; k++) begin
			answer(k ? cmd_read_ap : cmd_read, n);
			for (int i = 0; i < 8; i++) begin
				chk({pattern_valid, pattern_data, read_from_array}, {1'b1, i[0], 1'b0});
				lw(1);
			end
			chk(pattern_valid, 1'b0);
		end
		mode(3'h3, 19'h00005);
		answer(cmd_read, n);
		chk(n, 32'd40);
		mode(3'h3, 19'h00003);
		answer(cmd_read, n);
		chk({read_from_array, pattern_valid}, 2'h2);
		send(cmd_write, 3'h0, 19'h0);
		lw(2);
		chk(array_write_en, 1'b1);
		mode(3'h3, 19'h00004);
		@(posedge ref_clk) arst_n <= 1'b0;
		lw(3);
		@(posedge ref_clk) arst_n <= 1'b1;
		lw(3);
		chk({status.cal_pattern_on, column_write_latency}, 5'h05);
		answer(cmd_read, n);
		chk(read_from_array, 1'b1);
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		lw(3);
		@(posedge ref_clk) arst_n <= 1'b1;
		lw(3);
		t_latency();
		t_refresh();
		t_term();
		t_pattern();
		conclude();
	end
endmodule
bind mode_reg_ctrl mode_reg_ctrl_asserts u_chk (.arst_n(arst_n), .link_clk(link_clk),
	.link_cmd(link_cmd), .additive_latency(additive_latency),
	.nominal_termination(nominal_termination), .write_leveling(write_leveling),
	.active_termination(active_termination), .read_from_array(read_from_array),
	.array_write_en(array_write_en), .pattern_valid(pattern_valid), .pattern_data(pattern_data),
	.column_write_latency(column_write_latency), .total_write_latency(total_write_latency));
